// File: src/dpm_fifo.sv
// First-in first-out byte buffer held in flip-flops.
module dpm_fifo
  import dpm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  output logic not_full,
  input wire logic pop,
  output logic not_empty,
  output logic [WIDTH-1:0] pop_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic do_push;
  logic do_pop;

  // A push into a full buffer or a pop from an empty one is dropped.
  assign do_push = push & (count_r != FULL);
  assign do_pop = pop & (count_r != '0);
  assign not_full = (count_r != FULL);
  assign not_empty = (count_r != '0);
  assign pop_data = mem_r[rd_ptr_r];

  // Pointers wrap at the depth, so bytes leave in arrival order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (do_push) wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      if (do_pop) rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      if (do_push && !do_pop) count_r <= count_r + 1'b1;
      else if (do_pop && !do_push) count_r <= count_r - 1'b1;
    end
  end

  // Each entry loads only when the write pointer names it.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mem_r[i] <= '0;
      else if (ce && do_push && wr_ptr_r == AW'(i)) mem_r[i] <= push_data;
    end
  end
endmodule : dpm_fifo

// File: src/dpm_mailbox.sv
// Dual-port processor mailbox: host port, parasite port and channel storage.
// Overview of operation
// RULE1: Each port decodes three select bits into eight byte locations when selected.
// RULE2: Each channel has a read and a write register; direction picks one.
// RULE3: Even locations return channel flags; location zero adds general status (parasite location zero returns the flags only).
// RULE4: Channel one parasite-to-host data passes a 24-byte buffer at location one.
// RULE5: Channel one host-to-parasite data is a single-byte latch.
// RULE6: Channels two and four are single-byte latches both ways.
// RULE7: Channel three uses a two-byte buffer in each direction.
// RULE8: Buffers deliver bytes in the order they were written.
// RULE9: A written byte stays held until the receiver reads it (a single-byte latch written again before the read takes the new byte).
// RULE10: Only the host writes a status register, at location zero.
// RULE11: The host gives select and direction valid while phase two is high.
// RULE12: Parasite accesses are timed by active-low read and write strobes.
// RULE13: Host reset initialises everything and drives the parasite reset.
// RULE14: Outputs parasite interrupt, parasite non-maskable interrupt, host interrupt.
// RULE15: Transfer request output and acknowledge input serve a DMA controller.
// RULE16: Both chip selects low together halts the parasite system.
// RULE17: Flags show unread incoming data and room in the outgoing register.
module dpm_mailbox
  import dpm_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic PAR_CLK,
  input wire logic HOST_SELECT_N,
  input wire logic [2:0] HOST_REG_SEL,
  input wire logic HOST_RW,
  input wire logic HOST_PHASE_TWO,
  input wire logic [7:0] HOST_BUS_BYTE_IN,
  output logic [7:0] HOST_BUS_BYTE_OUT,
  output logic HOST_BUS_BYTE_OE,
  input wire logic PARASITE_SELECT_N,
  input wire logic [2:0] PARASITE_REG_SEL,
  input wire logic PARASITE_RD_STROBE_N,
  input wire logic PARASITE_WR_STROBE_N,
  input wire logic [7:0] PARASITE_BUS_BYTE_IN,
  output logic [7:0] PARASITE_BUS_BYTE_OUT,
  output logic PARASITE_BUS_BYTE_OE,
  output logic PARASITE_RESET_OUT,
  output logic PARASITE_IRQ_OUT,
  output logic PARASITE_NMI_OUT,
  output logic HOST_IRQ_OUT,
  output logic XFER_REQUEST,
  input wire logic XFER_ACKNOWLEDGE,
  output logic PARASITE_HALT
);
  // Host-clock synchronisers and host access state.
  logic [15:0] hmeta_r;
  logic [15:0] hsync_r;
  logic req_s, psel_s, hsel_s, hrw_s, ph2_s;
  logic [2:0] hreg_s;
  logic [7:0] hdata_s;
  logic ph2_prev_r;
  logic ack_t_r;
  logic h_go, p_go, hw, hr, pw, pr;
  logic [7:0] h_rdata_r, h_rd_nxt;
  logic [7:0] p_rdata_r, p_rd_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  // Channel storage.
  logic [NLAT-1:0] lat_full_r, lat_set, lat_clr;
  logic [7:0] lat_data_r [NLAT];
  logic c1_push, c1_pop, c1_nf, c1_ne;
  logic c3h_push, c3h_pop, c3h_nf, c3h_ne;
  logic c3p_push, c3p_pop, c3p_nf, c3p_ne;
  logic [7:0] c1_q, c3h_q, c3p_q;
  // Link-clock synchronisers and handshake.
  logic [1:0] ce_meta_r;
  logic pce;
  logic [15:0] pmeta_r;
  logic [15:0] psync_r;
  logic ack_s, lsel_s, rd_n_s, wr_n_s, xack_s;
  logic [2:0] preg_s;
  logic [7:0] pdata_s;
  logic p_act, p_prev_r;
  logic req_t_r, req_wr_r;
  logic [2:0] req_addr_r;
  logic [7:0] req_data_r;
  logic [7:0] p_out_r;
  dpm_link_state_type lstate_r;

  // Flag byte: unread incoming data and room outgoing.
  function automatic logic [7:0] flags(input logic avail, input logic space);
    logic [7:0] f;
    f = 8'h00;
    f[FLAG_AVAIL_BIT] = avail;
    f[FLAG_SPACE_BIT] = space;
    return f;
  endfunction : flags

  // Host pins and the link request toggle pass two flip-flops.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hmeta_r <= HSYNC_RST;
      hsync_r <= HSYNC_RST;
    end else if (CE) begin
      hmeta_r <= {req_t_r, PARASITE_SELECT_N, HOST_SELECT_N, HOST_RW,
                  HOST_PHASE_TWO, HOST_REG_SEL, HOST_BUS_BYTE_IN};
      hsync_r <= hmeta_r;
    end
  end
  assign {req_s, psel_s, hsel_s, hrw_s, ph2_s, hreg_s, hdata_s} = hsync_r;

  // Host access is taken on the rise of phase two with select low.
  assign h_go = ph2_s & ~ph2_prev_r & ~hsel_s; // see RULE1 see RULE11
  assign hw = h_go & ~hrw_s; // see RULE2
  assign hr = h_go & hrw_s;
  // A parasite access is a new request toggle from the link side.
  assign p_go = req_s ^ ack_t_r;
  assign pw = p_go & req_wr_r; // see RULE2 see RULE12
  assign pr = p_go & ~req_wr_r;

  // Decode both ports onto the channel storage and read multiplexers.
  always_comb begin
    lat_set = '0;
    lat_clr = '0;
    c1_push = 1'b0;
    c1_pop = 1'b0;
    c3h_push = 1'b0;
    c3h_pop = 1'b0;
    c3p_push = 1'b0;
    c3p_pop = 1'b0;
    ctrl_nxt = ctrl_r;
    h_rd_nxt = 8'h00;
    p_rd_nxt = 8'h00;
    // Host side locations.
    unique case (hreg_s)
      OFS_STAT_C1_FLAGS: begin
        h_rd_nxt = flags(c1_ne, ~lat_full_r[LAT_H2P1]) | 8'(ctrl_r); // see RULE3
        if (hw) begin
          // Control: bit 7 set or clear the named bits; host reads return them in bits 5..0.
          if (hdata_s[CTRL_SET_BIT]) begin
            ctrl_nxt = ctrl_r | hdata_s[CTRL_W-1:0]; // see RULE10
          end else begin
            ctrl_nxt = ctrl_r & ~hdata_s[CTRL_W-1:0];
          end
        end
      end
      OFS_C1_DATA: begin
        h_rd_nxt = c1_q;
        c1_pop = hr; // see RULE4
        lat_set[LAT_H2P1] = hw; // see RULE5
      end
      OFS_C2_FLAGS: begin
        h_rd_nxt = flags(lat_full_r[LAT_P2H2], ~lat_full_r[LAT_H2P2]);
      end
      OFS_C2_DATA: begin
        h_rd_nxt = lat_data_r[LAT_P2H2];
        lat_clr[LAT_P2H2] = hr; // see RULE6
        lat_set[LAT_H2P2] = hw;
      end
      OFS_C3_FLAGS: begin
        h_rd_nxt = flags(c3p_ne, c3h_nf); // see RULE17
      end
      OFS_C3_DATA: begin
        h_rd_nxt = c3p_q;
        c3p_pop = hr; // see RULE7
        c3h_push = hw;
      end
      OFS_C4_FLAGS: begin
        h_rd_nxt = flags(lat_full_r[LAT_P2H4], ~lat_full_r[LAT_H2P4]);
      end
      OFS_C4_DATA: begin
        h_rd_nxt = lat_data_r[LAT_P2H4];
        lat_clr[LAT_P2H4] = hr; // see RULE6
        lat_set[LAT_H2P4] = hw;
      end
    endcase
    // Parasite side locations; location zero accepts no write.
    unique case (req_addr_r)
      OFS_STAT_C1_FLAGS: begin
        p_rd_nxt = flags(lat_full_r[LAT_H2P1], c1_nf); // see RULE3
      end
      OFS_C1_DATA: begin
        p_rd_nxt = lat_data_r[LAT_H2P1];
        lat_clr[LAT_H2P1] = pr; // see RULE5
        c1_push = pw; // see RULE4
      end
      OFS_C2_FLAGS: begin
        p_rd_nxt = flags(lat_full_r[LAT_H2P2], ~lat_full_r[LAT_P2H2]);
      end
      OFS_C2_DATA: begin
        p_rd_nxt = lat_data_r[LAT_H2P2];
        lat_clr[LAT_H2P2] = pr; // see RULE6
        lat_set[LAT_P2H2] = pw;
      end
      OFS_C3_FLAGS: begin
        p_rd_nxt = flags(c3h_ne, c3p_nf); // see RULE17
      end
      OFS_C3_DATA: begin
        p_rd_nxt = c3h_q;
        c3h_pop = pr; // see RULE7
        c3p_push = pw;
      end
      OFS_C4_FLAGS: begin
        p_rd_nxt = flags(lat_full_r[LAT_H2P4], ~lat_full_r[LAT_P2H4]);
      end
      OFS_C4_DATA: begin
        p_rd_nxt = lat_data_r[LAT_H2P4];
        lat_clr[LAT_H2P4] = pr; // see RULE6
        lat_set[LAT_P2H4] = pw;
      end
    endcase
  end

  // Host port state, read data and the control register.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ph2_prev_r <= 1'b0;
      ack_t_r <= 1'b0;
      ctrl_r <= CTRL_RST; // see RULE13
      h_rdata_r <= BYTE_RST;
      p_rdata_r <= BYTE_RST;
    end else if (CE) begin
      ph2_prev_r <= ph2_s;
      ctrl_r <= ctrl_nxt;
      if (hr) h_rdata_r <= h_rd_nxt;
      if (p_go) begin
        ack_t_r <= req_s;
        p_rdata_r <= p_rd_nxt;
      end
    end
  end

  // Single-byte latches; a write in the same cycle as a read keeps full.
  for (genvar i = 0; i < NLAT; i++) begin : g_latch
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        lat_full_r[i] <= 1'b0;
        lat_data_r[i] <= BYTE_RST;
      end else if (CE) begin
        if (lat_set[i]) begin
          lat_full_r[i] <= 1'b1; // see RULE9
          lat_data_r[i] <= LAT_FROM_HOST[i] ? hdata_s : req_data_r;
        end else if (lat_clr[i]) begin
          lat_full_r[i] <= 1'b0;
        end
      end
    end
  end

  // Channel one parasite-to-host buffer.
  dpm_fifo #(.WIDTH(8), .DEPTH(C1_DEPTH)) u_c1_p2h (
    .clk(CLK),
    .rst_n(RSTN),
    .ce(CE),
    .push(c1_push),
    .push_data(req_data_r),
    .not_full(c1_nf),
    .pop(c1_pop),
    .not_empty(c1_ne),
    .pop_data(c1_q)
  ); // see RULE8

  // Channel three host-to-parasite buffer.
  dpm_fifo #(.WIDTH(8), .DEPTH(C3_DEPTH)) u_c3_h2p (
    .clk(CLK),
    .rst_n(RSTN),
    .ce(CE),
    .push(c3h_push),
    .push_data(hdata_s),
    .not_full(c3h_nf),
    .pop(c3h_pop),
    .not_empty(c3h_ne),
    .pop_data(c3h_q)
  );

  // Channel three parasite-to-host buffer.
  dpm_fifo #(.WIDTH(8), .DEPTH(C3_DEPTH)) u_c3_p2h (
    .clk(CLK),
    .rst_n(RSTN),
    .ce(CE),
    .push(c3p_push),
    .push_data(req_data_r),
    .not_full(c3p_nf),
    .pop(c3p_pop),
    .not_empty(c3p_ne),
    .pop_data(c3p_q)
  );

  // Interrupts, transfer request, parasite reset and collision halt.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PARASITE_RESET_OUT <= 1'b1; // see RULE13
      PARASITE_IRQ_OUT <= 1'b0;
      PARASITE_NMI_OUT <= 1'b0;
      HOST_IRQ_OUT <= 1'b0;
      XFER_REQUEST <= 1'b0;
      PARASITE_HALT <= 1'b0;
    end else if (CE) begin
      PARASITE_RESET_OUT <= ctrl_r[CTRL_PARASITE_RESET_OUT];
      PARASITE_IRQ_OUT <= (ctrl_r[CTRL_PIRQ1_EN] & lat_full_r[LAT_H2P1]) |
                          (ctrl_r[CTRL_PIRQ4_EN] & lat_full_r[LAT_H2P4]);
      PARASITE_NMI_OUT <= ctrl_r[CTRL_PNMI_EN] & c3h_ne; // see RULE14
      HOST_IRQ_OUT <= ctrl_r[CTRL_HIRQ_EN] & lat_full_r[LAT_P2H4];
      XFER_REQUEST <= ctrl_r[CTRL_XFER_EN] & c3h_ne; // see RULE15
      PARASITE_HALT <= ~hsel_s & ~psel_s; // see RULE16
    end
  end

  // Host data bus is driven while a selected read cycle is in phase two.
  assign HOST_BUS_BYTE_OUT = h_rdata_r;
  assign HOST_BUS_BYTE_OE = ph2_s & ~hsel_s & hrw_s;

  // Clock enable reaches the link domain through two flip-flops.
  always_ff @(posedge PAR_CLK or negedge RSTN) begin
    if (!RSTN) ce_meta_r <= 2'b00;
    else ce_meta_r <= {ce_meta_r[0], CE};
  end
  assign pce = ce_meta_r[1];

  // Parasite pins and the acknowledge toggle pass two flip-flops.
  always_ff @(posedge PAR_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pmeta_r <= PSYNC_RST;
      psync_r <= PSYNC_RST;
    end else if (pce) begin
      pmeta_r <= {ack_t_r, PARASITE_SELECT_N, PARASITE_RD_STROBE_N,
                  PARASITE_WR_STROBE_N, XFER_ACKNOWLEDGE, PARASITE_REG_SEL,
                  PARASITE_BUS_BYTE_IN};
      psync_r <= pmeta_r;
    end
  end
  assign {ack_s, lsel_s, rd_n_s, wr_n_s, xack_s, preg_s, pdata_s} = psync_r;

  // An access is live while a strobe is low and select or acknowledge holds.
  assign p_act = (~rd_n_s | ~wr_n_s) & (~lsel_s | xack_s); // see RULE12

  // Link handshake: capture on strobe fall, wait for the toggle to return.
  always_ff @(posedge PAR_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lstate_r <= LS_IDLE;
      p_prev_r <= 1'b0;
      req_t_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_addr_r <= OFS_STAT_C1_FLAGS;
      req_data_r <= BYTE_RST;
      p_out_r <= BYTE_RST;
    end else if (pce) begin
      p_prev_r <= p_act;
      unique case (lstate_r)
        LS_IDLE: begin
          if (p_act && !p_prev_r) begin
            // Acknowledge forces a channel three data access.
            req_addr_r <= xack_s ? OFS_C3_DATA : preg_s; // see RULE15
            req_wr_r <= ~wr_n_s;
            req_data_r <= pdata_s;
            req_t_r <= ~req_t_r;
            lstate_r <= LS_WAIT;
          end
        end
        LS_WAIT: begin
          if (ack_s == req_t_r) begin
            if (!req_wr_r) p_out_r <= p_rdata_r; // see RULE12
            lstate_r <= LS_IDLE;
          end
        end
      endcase
    end
  end

  // Parasite data bus is driven while the read strobe is low and select or acknowledge holds.
  assign PARASITE_BUS_BYTE_OUT = p_out_r;
  assign PARASITE_BUS_BYTE_OE = ~rd_n_s & (~lsel_s | xack_s);
endmodule : dpm_mailbox

// File: src/dpm_pkg.sv
// Package with the offsets, field positions and reset values of the mailbox.
package dpm_pkg;
  // Location offsets, the same on both ports.
  localparam logic [2:0] OFS_STAT_C1_FLAGS = 3'h0;
  localparam logic [2:0] OFS_C1_DATA = 3'h1;
  localparam logic [2:0] OFS_C2_FLAGS = 3'h2;
  localparam logic [2:0] OFS_C2_DATA = 3'h3;
  localparam logic [2:0] OFS_C3_FLAGS = 3'h4;
  localparam logic [2:0] OFS_C3_DATA = 3'h5;
  localparam logic [2:0] OFS_C4_FLAGS = 3'h6;
  localparam logic [2:0] OFS_C4_DATA = 3'h7;
  // Buffer depths.
  localparam int C1_DEPTH = 24;
  localparam int C3_DEPTH = 2;
  // Flag byte layout: unread data in, room in the outgoing register.
  localparam int FLAG_AVAIL_BIT = 7;
  localparam int FLAG_SPACE_BIT = 6;
  // Host control register: bit 7 chooses set or clear of bits 5..0.
  localparam int CTRL_SET_BIT = 7;
  localparam int CTRL_W = 6;
  localparam int CTRL_HIRQ_EN = 0;
  localparam int CTRL_PIRQ1_EN = 1;
  localparam int CTRL_PIRQ4_EN = 2;
  localparam int CTRL_PNMI_EN = 3;
  localparam int CTRL_XFER_EN = 4;
  localparam int CTRL_PARASITE_RESET_OUT = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  // Single-byte latches: index and writing side (1 = host).
  localparam int NLAT = 5;
  localparam int LAT_H2P1 = 0;
  localparam int LAT_H2P2 = 1;
  localparam int LAT_P2H2 = 2;
  localparam int LAT_H2P4 = 3;
  localparam int LAT_P2H4 = 4;
  localparam logic [NLAT-1:0] LAT_FROM_HOST = 5'h0b;
  // Reset values of the synchroniser chains and of the byte registers.
  localparam logic [15:0] HSYNC_RST = 16'h7000;
  localparam logic [15:0] PSYNC_RST = 16'h7000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Link side handshake states.
  typedef enum logic [1:0] {
    LS_IDLE = 2'b01,
    LS_WAIT = 2'b10
  } dpm_link_state_type;
endpackage : dpm_pkg

// File: test/dpm_mailbox_sva.sv
// Port assertions for the mailbox, bound to its top module.
module dpm_mailbox_sva
  import dpm_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PAR_CLK,
  input wire logic HOST_SELECT_N,
  input wire logic HOST_RW,
  input wire logic HOST_PHASE_TWO,
  input wire logic [7:0] HOST_BUS_BYTE_OUT,
  input wire logic HOST_BUS_BYTE_OE,
  input wire logic PARASITE_SELECT_N,
  input wire logic PARASITE_RD_STROBE_N,
  input wire logic [7:0] PARASITE_BUS_BYTE_OUT,
  input wire logic PARASITE_BUS_BYTE_OE,
  input wire logic PARASITE_RESET_OUT,
  input wire logic PARASITE_IRQ_OUT,
  input wire logic HOST_IRQ_OUT,
  input wire logic PARASITE_HALT
);
  timeunit 1ns;
  timeprecision 100ps;
  // Host side properties: reset state, bus enable, read data, halt.
  property p_rst_vals;
    @(posedge CLK) disable iff (!RSTN) $rose(RSTN) |->
      (PARASITE_RESET_OUT && !HOST_IRQ_OUT && !PARASITE_IRQ_OUT)
      ##1 !PARASITE_RESET_OUT;
  endproperty
  property p_host_oe;
    @(posedge CLK) disable iff (!RSTN) HOST_BUS_BYTE_OE ==
      $past(!HOST_SELECT_N && HOST_RW && HOST_PHASE_TWO, 2);
  endproperty
  property p_host_dout;
    @(posedge CLK) disable iff (!RSTN) $changed(HOST_BUS_BYTE_OUT) |->
      $past(!HOST_SELECT_N && HOST_RW && HOST_PHASE_TWO, 3);
  endproperty
  property p_halt_set;
    @(posedge CLK) disable iff (!RSTN)
      (!HOST_SELECT_N && !PARASITE_SELECT_N) [*4] |-> ##[0:1] PARASITE_HALT;
  endproperty
  property p_halt_clr;
    @(posedge CLK) disable iff (!RSTN) HOST_SELECT_N [*5] |-> !PARASITE_HALT;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("Bad reset state.");
  a_host_oe: assert property (p_host_oe)
    else $error("Host enable wrong.");
  a_host_dout: assert property (p_host_dout)
    else $error("Host data moved.");
  a_halt_set: assert property (p_halt_set)
    else $error("No halt.");
  a_halt_clr: assert property (p_halt_clr)
    else $error("Stray halt.");
  // Parasite side properties: enable needs the read strobe and follows it with select.
  property p_par_oe_cause;
    @(posedge PAR_CLK) disable iff (!RSTN)
      PARASITE_BUS_BYTE_OE |-> $past(!PARASITE_RD_STROBE_N, 2);
  endproperty
  property p_par_oe_set;
    @(posedge PAR_CLK) disable iff (!RSTN)
      (!PARASITE_RD_STROBE_N && !PARASITE_SELECT_N) [*4] |->
      PARASITE_BUS_BYTE_OE;
  endproperty
  property p_par_dout;
    @(posedge PAR_CLK) disable iff (!RSTN)
      $changed(PARASITE_BUS_BYTE_OUT) |-> $past(!PARASITE_RD_STROBE_N, 3);
  endproperty
  a_par_oe_cause: assert property (p_par_oe_cause)
    else $error("Parasite enable without strobe.");
  a_par_oe_set: assert property (p_par_oe_set)
    else $error("Parasite enable missing.");
  a_par_dout: assert property (p_par_dout)
    else $error("Parasite data moved.");
  // Main scenarios reached.
  c_host_rd: cover property (@(posedge CLK) $rose(HOST_BUS_BYTE_OE));
  c_par_rd: cover property (@(posedge PAR_CLK) $rose(PARASITE_BUS_BYTE_OE));
  c_halt: cover property (@(posedge CLK) $rose(PARASITE_HALT));
endmodule : dpm_mailbox_sva

bind dpm_mailbox dpm_mailbox_sva chk_u (
  .CLK(CLK), .RSTN(RSTN), .PAR_CLK(PAR_CLK),
  .HOST_SELECT_N(HOST_SELECT_N), .HOST_RW(HOST_RW),
  .HOST_PHASE_TWO(HOST_PHASE_TWO), .HOST_BUS_BYTE_OUT(HOST_BUS_BYTE_OUT),
  .HOST_BUS_BYTE_OE(HOST_BUS_BYTE_OE), .PARASITE_SELECT_N(PARASITE_SELECT_N),
  .PARASITE_RD_STROBE_N(PARASITE_RD_STROBE_N),
  .PARASITE_BUS_BYTE_OUT(PARASITE_BUS_BYTE_OUT),
  .PARASITE_BUS_BYTE_OE(PARASITE_BUS_BYTE_OE),
  .PARASITE_RESET_OUT(PARASITE_RESET_OUT),
  .PARASITE_IRQ_OUT(PARASITE_IRQ_OUT), .HOST_IRQ_OUT(HOST_IRQ_OUT),
  .PARASITE_HALT(PARASITE_HALT)
);

// File: test/dpm_par_model.sv
// Behavioural parasite processor driving the mailbox parasite port.
module dpm_par_model
  import dpm_pkg::*;
(
  input wire logic par_clk,
  output logic sel_n,
  output logic [2:0] reg_sel,
  output logic rd_n,
  output logic wr_n,
  output logic ack,
  output logic [7:0] dout,
  input wire logic [7:0] din
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus from time zero: deselected, strobes high.
  initial begin
    sel_n = 1'b1;
    reg_sel = 3'h0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ack = 1'b0;
    dout = 8'h00;
  end
  // One access; the strobe stays low long enough for the crossing.
  task automatic acc(input logic rd, input logic dma, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge par_clk);
    sel_n = dma;
    ack = dma;
    reg_sel = a;
    dout = d;
    @(negedge par_clk);
    if (rd) rd_n = 1'b0;
    else wr_n = 1'b0;
    repeat (14) @(negedge par_clk);
    q = din;
    rd_n = 1'b1;
    wr_n = 1'b1;
    @(negedge par_clk);
    sel_n = 1'b1;
    ack = 1'b0;
    dout = ~d; // Released data and address lines never keep the old value.
    reg_sel = ~a;
    repeat (6) @(negedge par_clk);
  endtask : acc
endmodule : dpm_par_model

// File: test/test_dpm_mailbox.sv
// Self-checking bench for the dual-port mailbox.
module test_dpm_mailbox
  import dpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RSTN, PAR_CLK, HOST_SELECT_N, HOST_RW, HOST_PHASE_TWO;
  logic [2:0] HOST_REG_SEL, PARASITE_REG_SEL, a;
  logic [7:0] HOST_BUS_BYTE_IN, HOST_BUS_BYTE_OUT, q;
  logic [7:0] PARASITE_BUS_BYTE_IN, PARASITE_BUS_BYTE_OUT;
  logic HOST_BUS_BYTE_OE, PARASITE_BUS_BYTE_OE, PARASITE_SELECT_N;
  logic PARASITE_RD_STROBE_N, PARASITE_WR_STROBE_N, XFER_ACKNOWLEDGE;
  logic PARASITE_RESET_OUT, PARASITE_IRQ_OUT, PARASITE_NMI_OUT;
  logic HOST_IRQ_OUT, XFER_REQUEST, PARASITE_HALT, CE;
  logic [2:0] lat [3] = '{3'h1, 3'h3, 3'h7};
  int compares = 0;
  int miscompares = 0;
  // Host clock 50 ns and link clock 48 ns.
  always #25 CLK = ~CLK;
  always #24 PAR_CLK = ~PAR_CLK;
  dpm_mailbox dut_u (
    .CLK(CLK), .RSTN(RSTN), .CE(CE), .PAR_CLK(PAR_CLK),
    .HOST_SELECT_N(HOST_SELECT_N), .HOST_REG_SEL(HOST_REG_SEL),
    .HOST_RW(HOST_RW), .HOST_PHASE_TWO(HOST_PHASE_TWO),
    .HOST_BUS_BYTE_IN(HOST_BUS_BYTE_IN), .HOST_BUS_BYTE_OUT(HOST_BUS_BYTE_OUT),
    .HOST_BUS_BYTE_OE(HOST_BUS_BYTE_OE), .PARASITE_SELECT_N(PARASITE_SELECT_N),
    .PARASITE_REG_SEL(PARASITE_REG_SEL),
    .PARASITE_RD_STROBE_N(PARASITE_RD_STROBE_N),
    .PARASITE_WR_STROBE_N(PARASITE_WR_STROBE_N),
    .PARASITE_BUS_BYTE_IN(PARASITE_BUS_BYTE_IN),
    .PARASITE_BUS_BYTE_OUT(PARASITE_BUS_BYTE_OUT),
    .PARASITE_BUS_BYTE_OE(PARASITE_BUS_BYTE_OE),
    .PARASITE_RESET_OUT(PARASITE_RESET_OUT),
    .PARASITE_IRQ_OUT(PARASITE_IRQ_OUT), .PARASITE_NMI_OUT(PARASITE_NMI_OUT),
    .HOST_IRQ_OUT(HOST_IRQ_OUT), .XFER_REQUEST(XFER_REQUEST),
    .XFER_ACKNOWLEDGE(XFER_ACKNOWLEDGE), .PARASITE_HALT(PARASITE_HALT)
  );
  dpm_par_model par_u (
    .par_clk(PAR_CLK), .sel_n(PARASITE_SELECT_N), .reg_sel(PARASITE_REG_SEL),
    .rd_n(PARASITE_RD_STROBE_N), .wr_n(PARASITE_WR_STROBE_N),
    .ack(XFER_ACKNOWLEDGE), .dout(PARASITE_BUS_BYTE_IN),
    .din(PARASITE_BUS_BYTE_OUT)
  );
  // Byte comparison with counting.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Host access; a read is compared with d.
  task automatic hx(input logic rd, input logic [2:0] ad, input logic [7:0] d);
    @(negedge CLK);
    HOST_SELECT_N = 1'b0;
    HOST_RW = rd;
    HOST_REG_SEL = ad;
    HOST_BUS_BYTE_IN = d;
    @(negedge CLK);
    HOST_PHASE_TWO = 1'b1;
    repeat (6) @(negedge CLK);
    if (rd) chk(HOST_BUS_BYTE_OUT, d);
    HOST_PHASE_TWO = 1'b0;
    @(negedge CLK);
    HOST_SELECT_N = 1'b1;
    HOST_BUS_BYTE_IN = ~d;
    repeat (3) @(negedge CLK);
  endtask : hx
  // Parasite access through the model; a read is compared with d.
  task automatic px(input logic rd, input logic [2:0] ad, input logic [7:0] d);
    logic [7:0] r;
    par_u.acc(rd, 1'b0, ad, d, r);
    if (rd) chk(r, d);
  endtask : px
  // Reset held three cycles, then time for the link side to start.
  task automatic do_reset();
    @(negedge CLK);
    RSTN = 1'b0;
    repeat (3) @(negedge CLK);
    chk({7'h00, PARASITE_RESET_OUT}, 8'h01);
    RSTN = 1'b1;
    repeat (4) @(negedge PAR_CLK);
  endtask : do_reset
  // All flag locations of an empty mailbox on both ports.
  task automatic idle_flags();
    for (int i = 0; i < 8; i += 2) begin
      hx(1'b1, 3'(i), 8'h40);
      px(1'b1, 3'(i), 8'h40);
    end
  endtask : idle_flags
  // Verdict and end of run.
  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence of scenarios.
  initial begin
    CLK = 1'b0;
    PAR_CLK = 1'b0;
    CE = 1'b1;
    RSTN = 1'b0;
    HOST_SELECT_N = 1'b1;
    HOST_RW = 1'b1;
    HOST_PHASE_TWO = 1'b0;
    HOST_REG_SEL = 3'h0;
    HOST_BUS_BYTE_IN = 8'h00;
    do_reset();
    idle_flags();
    foreach (lat[i]) begin
      a = lat[i];
      hx(1'b0, a, {5'h0b, a});
      px(1'b1, a - 3'h1, 8'hc0);
      px(1'b1, a, {5'h0b, a});
      px(1'b1, a - 3'h1, 8'h40);
      if (a != 3'h1) begin
        px(1'b0, a, {5'h15, a});
        hx(1'b1, a - 3'h1, 8'hc0);
        hx(1'b1, a, {5'h15, a});
      end
    end
    hx(1'b0, 3'h0, 8'h98);
    for (int i = 1; i < 4; i++) hx(1'b0, 3'h5, 8'(8'h30 + i));
    hx(1'b1, 3'h4, 8'h00);
    chk({6'h00, PARASITE_NMI_OUT, XFER_REQUEST}, 8'h03);
    par_u.acc(1'b1, 1'b1, 3'h0, 8'h00, q);
    chk(q, 8'h31);
    px(1'b1, 3'h5, 8'h32);
    chk({6'h00, PARASITE_NMI_OUT, XFER_REQUEST}, 8'h00);
    hx(1'b0, 3'h0, 8'h18);
    px(1'b0, 3'h5, 8'h41);
    px(1'b0, 3'h5, 8'h42);
    px(1'b1, 3'h4, 8'h00);
    hx(1'b1, 3'h5, 8'h41);
    hx(1'b1, 3'h5, 8'h42);
    hx(1'b0, 3'h0, 8'ha3);
    hx(1'b1, 3'h0, 8'h63);
    chk({7'h00, PARASITE_RESET_OUT}, 8'h01);
    hx(1'b0, 3'h1, 8'h77);
    chk({7'h00, PARASITE_IRQ_OUT}, 8'h01);
    px(1'b1, 3'h1, 8'h77);
    chk({7'h00, PARASITE_IRQ_OUT}, 8'h00);
    px(1'b0, 3'h7, 8'h99);
    chk({7'h00, HOST_IRQ_OUT}, 8'h01);
    hx(1'b1, 3'h7, 8'h99);
    chk({7'h00, HOST_IRQ_OUT}, 8'h00);
    // Channel four host-to-parasite latch raises the parasite interrupt.
    hx(1'b0, 3'h0, 8'h84);
    hx(1'b0, 3'h7, 8'h66);
    chk({7'h00, PARASITE_IRQ_OUT}, 8'h01);
    px(1'b1, 3'h7, 8'h66);
    chk({7'h00, PARASITE_IRQ_OUT}, 8'h00);
    hx(1'b0, 3'h0, 8'h3f);
    chk({7'h00, PARASITE_RESET_OUT}, 8'h00);
    for (int i = 0; i < 25; i++) px(1'b0, 3'h1, 8'(i + 16));
    hx(1'b1, 3'h0, 8'hc0);
    px(1'b1, 3'h0, 8'h00);
    for (int i = 0; i < 24; i++) hx(1'b1, 3'h1, 8'(i + 16));
    @(negedge CLK);
    HOST_SELECT_N = 1'b0;
    fork
      px(1'b0, 3'h0, 8'hff);
      begin
        repeat (12) @(negedge CLK);
        chk({7'h00, PARASITE_HALT}, 8'h01);
      end
    join
    @(negedge CLK);
    HOST_SELECT_N = 1'b1;
    repeat (6) @(negedge CLK);
    chk({7'h00, PARASITE_HALT}, 8'h00);
    // With the clock enable low a host write must not land.
    CE = 1'b0;
    hx(1'b0, 3'h3, 8'h21);
    CE = 1'b1;
    px(1'b1, 3'h2, 8'h40);
    hx(1'b1, 3'h0, 8'h40);
    hx(1'b0, 3'h2, 8'h55);
    px(1'b1, 3'h2, 8'h40);
    hx(1'b0, 3'h3, 8'h12);
    do_reset();
    idle_flags();
    tally_and_finish();
  end
  // Cuts a hung run short far beyond the expected length.
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    tally_and_finish();
  end
endmodule : test_dpm_mailbox
